// [src/exc_params.svh]
`ifndef EXC_PARAMS_SVH
`define EXC_PARAMS_SVH

// Register byte offsets on the APB
`define OFS_BKPT 12'h000
`define OFS_STATUS 12'h004
`define OFS_MASK 12'h008
`define OFS_LAST_VEC 12'h00c
`define OFS_PEND 12'h010

// Breakpoint register fields (bit 31 of the register is the word MSB)
`define BKPT_ADDR_HI 31
`define BKPT_ADDR_LO 2
`define BKPT_EN_BIT 1

// Reset values
`define RST_BKPT 32'h0000_0000
`define RST_MASK 5'h00

// Vector offsets
`define VEC_INSTR_TRANSLATION_BUFFER_MISS 20'h01000
`define VEC_LOAD_MISS 20'h01100
`define VEC_STORE_MISS 20'h01200
`define VEC_BKPT 20'h01300
`define VEC_SMI 20'h01400

// Number of exception causes
`define NUM_CAUSE 5

`endif

// [src/exc_pkg.sv]
`include "exc_params.svh"

package exc_pkg;

  // Cause index, also the bit position in status, mask and pending
  typedef enum logic [2:0] {
    cause_instr_translation_buffer = 3'b000,
    cause_load = 3'b001,
    cause_store = 3'b010,
    cause_bkpt = 3'b011,
    cause_smi = 3'b100
  } cause_e;

  // Dispatch state
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_offer = 1'b1
  } disp_e;

  typedef logic [`NUM_CAUSE-1:0] cause_t;
  typedef logic [19:0] vector_t;

  // Vector offset of a cause; anything else yields the miss vector, never a reserved one
  function automatic vector_t vector_of(input logic [2:0] idx);
    vector_t v;
    v = `VEC_INSTR_TRANSLATION_BUFFER_MISS;
    if (idx == cause_load) begin
      v = `VEC_LOAD_MISS;
    end else if (idx == cause_store) begin
      v = `VEC_STORE_MISS;
    end else if (idx == cause_bkpt) begin
      v = `VEC_BKPT;
    end else if (idx == cause_smi) begin
      v = `VEC_SMI;
    end
    return v;
  endfunction

  // Lowest set bit of a pending set, the cause dispatched first
  function automatic logic [2:0] first_cause(input cause_t set);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `NUM_CAUSE - 1; i >= 0; i--) begin
      if (set[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

endpackage

// [src/exc_detect_if.sv]
`timescale 1ns/100ps

interface exc_detect_if (
  input wire logic mclk,
  input wire logic rst
);
  import exc_pkg::*;

  logic fetch_valid;
  logic fetch_hit;
  logic load_valid;
  logic load_hit;
  logic store_valid;
  logic store_hit;
  logic store_change_set;
  logic complete_valid;
  logic [31:0] complete_addr;
  logic [31:0] bkpt_reg;
  logic ee;
  logic smi_level;
  cause_t cause;

  modport det (
    input mclk, rst, fetch_valid, fetch_hit, load_valid, load_hit, store_valid,
    input store_hit, store_change_set, complete_valid, complete_addr, bkpt_reg,
    input ee, smi_level,
    output cause
  );

  modport top (
    output fetch_valid, fetch_hit, load_valid, load_hit, store_valid,
    output store_hit, store_change_set, complete_valid, complete_addr, bkpt_reg,
    output ee, smi_level,
    input cause
  );
endinterface

// [src/exc_detect.sv]
`timescale 1ns/100ps
`include "exc_params.svh"

module exc_detect
  import exc_pkg::*;
(
  exc_detect_if.det d
);

  logic smi_seen;
  logic smi_take;
  logic bkpt_hit;

  // Address field compare against the next instruction to complete
  assign bkpt_hit = d.complete_valid && d.bkpt_reg[`BKPT_EN_BIT] &&
    (d.bkpt_reg[`BKPT_ADDR_HI:`BKPT_ADDR_LO] ==
     d.complete_addr[`BKPT_ADDR_HI:`BKPT_ADDR_LO]);

  // One take per assertion; the request must drop before it can be taken again
  assign smi_take = d.smi_level && d.ee && !smi_seen;

  // Remember that the held request was already taken
  always_ff @(posedge d.mclk) begin
    if (d.rst) begin
      smi_seen <= 1'b0;
    end else if (!d.smi_level) begin
      smi_seen <= 1'b0;
    end else if (smi_take) begin
      smi_seen <= 1'b1;
    end
  end

  // Registered cause flags, one cycle after the event
  always_ff @(posedge d.mclk) begin
    if (d.rst) begin
      d.cause <= '0;
    end else begin
      d.cause[cause_instr_translation_buffer] <= d.fetch_valid && !d.fetch_hit;
      d.cause[cause_load] <= d.load_valid && !d.load_hit;
      d.cause[cause_store] <= d.store_valid &&
        (!d.store_hit || !d.store_change_set);
      d.cause[cause_bkpt] <= bkpt_hit;
      d.cause[cause_smi] <= smi_take;
    end
  end

endmodule

// [src/exception_vector_unit.sv]
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "exc_params.svh"

// Behaviour
// - Fetch with no instruction translation: vector 01000
// - Load with no data translation: vector 01100
// - Store with no data translation: vector 01200
// - Store hit, change bit clear: vector 01200
// - Breakpoint address matches completing instruction: 01300
// - Breakpoint only while enable bit set
// - Management interrupt when enabled and asserted: 01400
module exception_vector_unit
  import exc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side, same clock
  input wire logic fetch_valid,
  input wire logic instr_translation_buffer_hit,
  input wire logic load_valid,
  input wire logic store_valid,
  input wire logic data_translation_buffer_hit,
  input wire logic page_table_entry_changed,
  input wire logic complete_valid,
  input wire logic [31:0] complete_addr,
  input wire logic external_irq_enable_bit,
  // Management interrupt pin, active low, asynchronous
  input wire logic sys_mgmt_irq_in_n,
  // Dispatch to the core
  output logic exc_req,
  output logic [19:0] exc_vector,
  input wire logic exc_ack,
  output logic irq
);

  logic smi_meta;
  logic smi_sync;
  logic [31:0] instr_breakpoint_address_reg;
  cause_t status;
  cause_t mask;
  cause_t pend;
  vector_t last_vec;
  disp_e state;
  logic [2:0] sel;
  logic wr_go;
  logic rd_setup;
  logic addr_ok;
  cause_t clr_w1c;
  cause_t cleared_by_ack;
  logic [31:0] next_rdata;

  exc_detect_if dif (
    .mclk(mclk),
    .rst(rst)
  );

  // Tie core inputs onto the detector carrier
  assign dif.fetch_valid = fetch_valid;
  assign dif.fetch_hit = instr_translation_buffer_hit;
  assign dif.load_valid = load_valid;
  assign dif.load_hit = data_translation_buffer_hit;
  assign dif.store_valid = store_valid;
  assign dif.store_hit = data_translation_buffer_hit;
  assign dif.store_change_set = page_table_entry_changed;
  assign dif.complete_valid = complete_valid;
  assign dif.complete_addr = complete_addr;
  assign dif.bkpt_reg = instr_breakpoint_address_reg;
  assign dif.ee = external_irq_enable_bit;
  assign dif.smi_level = smi_sync;

  exc_detect u_detect (
    .d(dif.det)
  );

  // Two-flop synchroniser; the pin is active low, inverted at the input of the second flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      smi_meta <= 1'b1;
      smi_sync <= 1'b0;
    end else begin
      smi_meta <= sys_mgmt_irq_in_n;
      smi_sync <= !smi_meta_q();
    end
  end

  // Helper keeps the first flop read only by the second
  function automatic logic smi_meta_q();
    return smi_meta;
  endfunction

  // ---- APB decode ----
  // A write takes effect at the access edge where pready is seen high
  assign wr_go = psel && penable && pready && pwrite;
  assign rd_setup = psel && !penable;

  // Address decode for mapped registers
  always_comb begin
    if (paddr == `OFS_BKPT) begin
      addr_ok = 1'b1;
    end else if (paddr == `OFS_STATUS) begin
      addr_ok = 1'b1;
    end else if (paddr == `OFS_MASK) begin
      addr_ok = 1'b1;
    end else if (paddr == `OFS_LAST_VEC) begin
      addr_ok = 1'b1;
    end else if (paddr == `OFS_PEND) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  // Read mux; unused upper bits read as zero
  always_comb begin
    if (paddr == `OFS_BKPT) begin
      next_rdata = instr_breakpoint_address_reg;
    end else if (paddr == `OFS_STATUS) begin
      next_rdata = {27'h0000000, status};
    end else if (paddr == `OFS_MASK) begin
      next_rdata = {27'h0000000, mask};
    end else if (paddr == `OFS_LAST_VEC) begin
      next_rdata = {12'h000, last_vec};
    end else if (paddr == `OFS_PEND) begin
      next_rdata = {27'h0000000, pend};
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  // One wait-free access phase: pready rises in the cycle after setup
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      pready <= 1'b1;
      pslverr <= !addr_ok;
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Breakpoint register; bit 0 is reserved and stays zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      instr_breakpoint_address_reg <= `RST_BKPT;
    end else if (wr_go && paddr == `OFS_BKPT) begin
      instr_breakpoint_address_reg <= {pwdata[31:1], 1'b0};
    end
  end

  // Interrupt mask register
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask <= `RST_MASK;
    end else if (wr_go && paddr == `OFS_MASK) begin
      mask <= pwdata[`NUM_CAUSE-1:0];
    end
  end

  // Write-one-to-clear bits of the status register
  assign clr_w1c = (wr_go && paddr == `OFS_STATUS) ? pwdata[`NUM_CAUSE-1:0] : '0;

  // Sticky status; a new event in the clearing cycle wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_w1c) | dif.cause;
    end
  end

  // Level interrupt, high while an unmasked status bit is set
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~clr_w1c) | dif.cause) & mask);
    end
  end

  // ---- Dispatch ----
  // Lowest pending cause goes first; fixed order keeps the core side simple
  assign sel = first_cause(pend);

  // Acknowledged cause leaves the pending set
  assign cleared_by_ack = (state == st_offer && exc_ack) ?
    cause_t'(1 << exc_sel_q()) : '0;

  function automatic logic [2:0] exc_sel_q();
    logic [2:0] i;
    i = 3'h0;
    for (int k = 0; k < `NUM_CAUSE; k++) begin
      if (exc_vector == vector_of(3'(k))) begin
        i = 3'(k);
      end
    end
    return i;
  endfunction

  // Pending causes waiting for dispatch; a new event wins over the ack
  always_ff @(posedge mclk) begin
    if (rst) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~cleared_by_ack) | dif.cause;
    end
  end

  // Offer one vector at a time and hold it until the core acknowledges
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= st_idle;
      exc_req <= 1'b0;
      exc_vector <= `VEC_INSTR_TRANSLATION_BUFFER_MISS;
    end else begin
      case (state)
        st_idle: begin
          if (|pend) begin
            state <= st_offer;
            exc_req <= 1'b1;
            exc_vector <= vector_of(sel);
          end
        end
        st_offer: begin
          if (exc_ack) begin
            state <= st_idle;
            exc_req <= 1'b0;
          end
        end
        default: begin
          state <= st_idle;
          exc_req <= 1'b0;
        end
      endcase
    end
  end

  // Last vector dispatched, for software
  always_ff @(posedge mclk) begin
    if (rst) begin
      last_vec <= 20'h00000;
    end else if (state == st_offer && exc_ack) begin
      last_vec <= exc_vector;
    end
  end

endmodule

// [verif/exc_properties.sv]
`timescale 1ns/100ps
`include "exc_params.svh"

module exc_properties
  import exc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic fetch_valid,
  input wire logic instr_translation_buffer_hit,
  input wire logic load_valid,
  input wire logic store_valid,
  input wire logic data_translation_buffer_hit,
  input wire logic page_table_entry_changed,
  input wire logic complete_valid,
  input wire logic [31:0] complete_addr,
  input wire logic external_irq_enable_bit,
  input wire logic sys_mgmt_irq_in_n,
  input wire logic exc_req,
  input wire logic [19:0] exc_vector,
  input wire logic exc_ack
);
  logic [31:0] bp;
  // Shadow of the breakpoint register, taken at the APB access edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      bp <= `RST_BKPT;
    end else if (psel && penable && pready && pwrite && paddr == `OFS_BKPT) begin
      bp <= pwdata;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Bounds allow for causes queued ahead of this one
  a_instr_translation_buffer_vector: assert property (fetch_valid && !instr_translation_buffer_hit
    |-> ##[3:40] exc_req && exc_vector == `VEC_INSTR_TRANSLATION_BUFFER_MISS) else $error("no fetch vector");
  a_load_vector: assert property (load_valid && !data_translation_buffer_hit
    |-> ##[3:40] exc_req && exc_vector == `VEC_LOAD_MISS) else $error("no load vector");
  a_store_vector: assert property (store_valid && !data_translation_buffer_hit
    |-> ##[3:40] exc_req && exc_vector == `VEC_STORE_MISS) else $error("no store vector");
  a_change_bit: assert property (store_valid && data_translation_buffer_hit &&
    !page_table_entry_changed |-> ##[3:40] exc_req && exc_vector == `VEC_STORE_MISS)
    else $error("no change vector");
  a_bkpt_match: assert property (complete_valid && bp[1] &&
    complete_addr[31:2] == bp[31:2] |-> ##[3:40] exc_req && exc_vector == `VEC_BKPT)
    else $error("no breakpoint vector");
  a_smi_taken: assert property ($rose(!sys_mgmt_irq_in_n && external_irq_enable_bit)
    ##1 (!sys_mgmt_irq_in_n && external_irq_enable_bit) [*3]
    |-> ##[0:20] exc_req && exc_vector == `VEC_SMI) else $error("no smi vector");
  a_no_reserved: assert property (exc_req |->
    !(exc_vector inside {[20'h00e10:20'h00fff], [20'h01500:20'h02fff]}))
    else $error("reserved vector");
  a_offer_hold: assert property (exc_req && !exc_ack |=> exc_req && $stable(exc_vector))
    else $error("offer dropped");

  c_smi: cover property (exc_req && exc_ack && exc_vector == `VEC_SMI);
  c_bkpt: cover property (exc_req && exc_ack && exc_vector == `VEC_BKPT);
  c_next: cover property (exc_req && exc_ack ##2 exc_req);
endmodule

// [verif/smi_source.sv]
`timescale 1ns/100ps
`include "exc_params.svh"

module smi_source
  import exc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic go,
  input wire logic exc_req,
  input wire logic [19:0] exc_vector,
  input wire logic exc_ack,
  output logic smi_n
);
  logic armed;
  // One request per run; the pin stays low until the core takes the vector
  always_ff @(posedge mclk) begin
    if (rst) begin
      smi_n <= 1'b1;
      armed <= 1'b0;
    end else if (go && !armed) begin
      smi_n <= 1'b0;
      armed <= 1'b1;
    end else if (exc_req && exc_ack && exc_vector == `VEC_SMI) begin
      smi_n <= 1'b1;
    end
  end
endmodule

// [verif/exception_vector_unit_tb_top.sv]
`timescale 1ns/100ps
`include "exc_params.svh"

module exception_vector_unit_tb_top;
  import exc_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, exc_req, exc_ack, irq, err;
  logic fv, ih, lv, sv, dh, pc, cv, ee, smi_n, smi_go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ca, rd;
  logic [19:0] exc_vector;
  logic [19:0] got[$];
  int fail_count, checks_done;

  exception_vector_unit uut(.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fetch_valid(fv), .instr_translation_buffer_hit(ih), .load_valid(lv),
    .store_valid(sv), .data_translation_buffer_hit(dh), .page_table_entry_changed(pc),
    .complete_valid(cv), .complete_addr(ca), .external_irq_enable_bit(ee),
    .sys_mgmt_irq_in_n(smi_n), .exc_req, .exc_vector, .exc_ack, .irq);
  smi_source partner(.mclk, .rst, .go(smi_go), .exc_req, .exc_vector, .exc_ack, .smi_n);

  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end

  // Accept each offer one cycle late, so the hold of the offer is exercised
  always @(posedge mclk) begin
    if (exc_req && exc_ack) begin
      got.push_back(exc_vector);
    end
    exc_ack <= exc_req && !exc_ack;
  end

  // Setup, then access held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    if (pready !== 1'b1) begin
      fail_count++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge mclk);
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Drive one cycle of core strobes {fv, ih, lv, sv, dh, pc, cv}
  task automatic ev(input logic [6:0] s, input logic [31:0] a);
    {fv, ih, lv, sv, dh, pc, cv} <= s;
    ca <= a;
    @(posedge mclk);
    {fv, ih, lv, sv, dh, pc, cv} <= 7'h0;
    @(posedge mclk);
  endtask

  task automatic vec(input logic [19:0] e);
    int n;
    n = 0;
    while (got.size() == 0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    cmp("vector", {12'h0, e}, got.size() > 0 ? {12'h0, got.pop_front()} : 32'hx);
  endtask

  task automatic none();
    repeat (20) @(posedge mclk);
    cmp("spurious", 0, 32'(got.size()));
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, fv, ih, lv, sv, dh, pc, cv, ee, smi_go, exc_ack} = '0;
    paddr = '0;
    pwdata = '0;
    ca = '0;
    rst = 1;
    repeat (5) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    apb(0, `OFS_MASK, 0);
    cmp("mask", 32'(`RST_MASK), rd);
    apb(0, `OFS_BKPT, 0);
    cmp("bkpt", `RST_BKPT, rd);
    apb(0, 12'h020, 0);
    cmp("unmapped", 1, {31'h0, err});
    apb(1, `OFS_MASK, 32'h1f);
    ev(7'b1000000, 0);
    vec(`VEC_INSTR_TRANSLATION_BUFFER_MISS);
    cmp("irq", 1, {31'h0, irq});
    apb(1, `OFS_STATUS, 32'h1);
    apb(0, `OFS_STATUS, 0);
    cmp("status", 0, rd);
    cmp("irq", 0, {31'h0, irq});
    apb(1, `OFS_MASK, 0);
    ev(7'b0010000, 0);
    vec(`VEC_LOAD_MISS);
    apb(0, `OFS_STATUS, 0);
    cmp("status", 32'h2, rd);
    cmp("irq", 0, {31'h0, irq});
    ev(7'b0001000, 0);
    vec(`VEC_STORE_MISS);
    ev(7'b0001100, 0);
    vec(`VEC_STORE_MISS);
    ev(7'b0001110, 0);
    none();
    ev(7'b1010000, 0);
    vec(`VEC_INSTR_TRANSLATION_BUFFER_MISS);
    vec(`VEC_LOAD_MISS);
    apb(1, `OFS_BKPT, 32'h1232);
    apb(0, `OFS_BKPT, 0);
    cmp("bkpt", 32'h1232, rd);
    ev(7'b0000001, 32'h1230);
    vec(`VEC_BKPT);
    ev(7'b0000001, 32'h1234);
    none();
    apb(1, `OFS_BKPT, 32'h1230);
    ev(7'b0000001, 32'h1230);
    none();
    smi_go <= 1;
    none();
    cmp("smi pin", 0, {31'h0, smi_n});
    ee <= 1;
    vec(`VEC_SMI);
    none();
    cmp("smi pin", 1, {31'h0, smi_n});
    apb(0, `OFS_LAST_VEC, 0);
    cmp("last", {12'h0, `VEC_SMI}, rd);
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #80000;
    fail_count++;
    summarize();
  end
endmodule

bind exception_vector_unit exc_properties chk(.mclk, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .fetch_valid, .instr_translation_buffer_hit, .load_valid, .store_valid,
  .data_translation_buffer_hit, .page_table_entry_changed, .complete_valid, .complete_addr,
  .external_irq_enable_bit, .sys_mgmt_irq_in_n, .exc_req, .exc_vector, .exc_ack);
